// [inc/ddw_defines.vh]
// Constants for the DDR3 write, precharge and self refresh device logic
`ifndef DDW_DEFINES_VH
`define DDW_DEFINES_VH

// ----------------------------------------
// APB register offsets (byte addresses)
// ----------------------------------------
`define DDW_OFF_MODE     12'h000
`define DDW_OFF_STAT     12'h004
`define DDW_OFF_RFCNT    12'h008
`define DDW_OFF_WINFO    12'h00C
`define DDW_OFF_DATA     12'h040
`define DDW_OFF_DATA_END 12'h07C

// ----------------------------------------
// MODE register fields and reset value
// ----------------------------------------
`define DDW_MODE_BL_LSB  0
`define DDW_MODE_AL_LSB  2
`define DDW_MODE_CWL_LSB 6
`define DDW_MODE_NOM_BIT 10
`define DDW_MODE_WR_BIT  11
`define DDW_MODE_RST     32'h00000140

// ----------------------------------------
// STAT register fields
// ----------------------------------------
`define DDW_STAT_SR_BIT    8
`define DDW_STAT_DLL_BIT   9
`define DDW_STAT_LOCK_BIT  10
`define DDW_STAT_ODT_BIT   11
`define DDW_STAT_WERR_BIT  12
`define DDW_STAT_BUSY_BIT  13

// ----------------------------------------
// Burst length selections
// ----------------------------------------
`define DDW_BL_FIX8 2'h0
`define DDW_BL_OTF  2'h1
`define DDW_BL_FIX4 2'h2

// ----------------------------------------
// Command codes {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define DDW_CMD_REF 4'h1
`define DDW_CMD_PRE 4'h2
`define DDW_CMD_ACT 4'h3
`define DDW_CMD_WR  4'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define DDW_CLK_MHZ    100
`define DDW_TCKE_NS    10
`define DDW_TCKE_CYC   ((`DDW_TCKE_NS * `DDW_CLK_MHZ) / 1000)
`define DDW_TREFI_NS   7800
`define DDW_TREFI_CYC  ((`DDW_TREFI_NS * `DDW_CLK_MHZ) / 1000)
`define DDW_TXSDLL_CK  512
`define DDW_CHOP_CK    4
`define DDW_WIN_CK     5

`endif

// [rtl/ddw_sync.v]
// Two-flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps

module ddw_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // ddw_sync

// [rtl/ddw_top.v]
// DDR3 device write capture, precharge and self refresh logic with APB registers
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "ddw_defines.vh"
module ddw_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ck,
  input  wire        cke,
  input  wire        cs_n,
  input  wire        ras_n,
  input  wire        cas_n,
  input  wire        we_n,
  input  wire [13:0] addr,
  input  wire [2:0]  ba,
  input  wire        odt,
  input  wire        mem_reset_n,
  input  wire        dqs,
  input  wire [7:0]  dq,
  input  wire        dm
);

  // Timing counts as integers, cut to the 10-bit timer width on purpose
  localparam integer TCKE_I   = `DDW_TCKE_CYC - 1;
  localparam integer TREFI_I  = `DDW_TREFI_CYC - 1;
  localparam integer XSDLL_I  = `DDW_TXSDLL_CK - 1;
  localparam [9:0]   TCKE_M1  = TCKE_I[9:0];
  localparam [9:0]   TREFI_M1 = TREFI_I[9:0];
  localparam [9:0]   XSDLL_M1 = XSDLL_I[9:0];

  // ----------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------
  wire [34:0] s;
  wire        s_ck, s_cke, s_odt, s_rstn, s_dqs, s_dm;
  wire [3:0]  s_cmd;
  wire [13:0] s_addr;
  wire [2:0]  s_ba;
  wire [7:0]  s_dq;

  ddw_sync #(.W(35)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({ck, cke, cs_n, ras_n, cas_n, we_n, addr, ba, odt, mem_reset_n, dqs, dq, dm}),
    .q     (s)
  );
  assign {s_ck, s_cke, s_cmd, s_addr, s_ba, s_odt, s_rstn, s_dqs, s_dq, s_dm} = s;
  reg ck_d, dqs_d, cke_prev;
  wire ck_rise  = s_ck & ~ck_d;
  wire dqs_rise = s_dqs & ~dqs_d;
  wire dqs_fall = ~s_dqs & dqs_d;
  // Pin reset acts like the block reset on device state
  wire rst_all  = ~rst_n | ~s_rstn;
  // Previous levels; CKE is registered only on clock edges
  always @(posedge clk) begin
    if (rst_all) begin
      ck_d     <= 1'b0;
      dqs_d    <= 1'b1; // Strobe parks high, so no false edge
      cke_prev <= 1'b0;
    end else begin
      ck_d  <= s_ck;
      dqs_d <= s_dqs;
      if (ck_rise)
        cke_prev <= s_cke;
    end
  end
  // ----------------------------------------
  // Mode, status and command decode
  // ----------------------------------------
  reg  [31:0] mode;
  reg         sr, dll_en, relock, odt_err, wr_err;
  reg  [7:0]  bank_open;
  wire [1:0]  bl_mode = mode[`DDW_MODE_BL_LSB +: 2];
  wire [4:0]  wl      = {1'b0, mode[`DDW_MODE_AL_LSB +: 4]} + {1'b0, mode[`DDW_MODE_CWL_LSB +: 4]};
  wire        rtt_on  = mode[`DDW_MODE_NOM_BIT] | mode[`DDW_MODE_WR_BIT];
  // In self refresh the command pins are ignored entirely
  wire        cmd_ok  = ck_rise & ~sr & cke_prev & s_cke;
  wire        sr_entry = ck_rise & ~sr & cke_prev & ~s_cke & (s_cmd == `DDW_CMD_REF);
  wire        wr_cmd   = cmd_ok & (s_cmd == `DDW_CMD_WR);
  // Burst chop decision for one WRITE
  function chop_sel;
    input [1:0] blm;
    input       a12;
    begin
      chop_sel = (blm == `DDW_BL_FIX4) | ((blm == `DDW_BL_OTF) & ~a12);
    end
  endfunction
  // ----------------------------------------
  // Bank state
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst_all) begin
      bank_open <= 8'h00;
    end else if (cmd_ok) begin
      if (s_cmd == `DDW_CMD_ACT)
        bank_open[s_ba] <= 1'b1;
      else if (s_cmd == `DDW_CMD_PRE) begin
        if (s_addr[10])
          bank_open <= 8'h00;
        else
          bank_open[s_ba] <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Self refresh, DLL and internal refresh
  // ----------------------------------------
  reg        ref_first;
  reg [9:0]  ref_tmr, lock_cnt;
  reg [31:0] ref_cnt;
  // Exit is taken on the CKE level, since the clock may be stopped
  always @(posedge clk) begin
    if (rst_all) begin
      sr        <= 1'b0;
      dll_en    <= 1'b1;
      relock    <= 1'b0;
      ref_first <= 1'b0;
      ref_tmr   <= 10'h000;
      lock_cnt  <= 10'h000;
      ref_cnt   <= 32'h00000000;
    end else if (sr_entry) begin
      sr        <= 1'b1;
      dll_en    <= 1'b0;
      relock    <= 1'b0;
      ref_first <= 1'b1;
      ref_tmr   <= 10'h000;
    end else if (sr && s_cke) begin
      sr       <= 1'b0;
      dll_en   <= 1'b1;
      relock   <= 1'b1;
      lock_cnt <= 10'h000;
    end else if (sr) begin
      if (ref_tmr == (ref_first ? TCKE_M1 : TREFI_M1)) begin
        ref_cnt   <= ref_cnt + 32'h00000001;
        ref_first <= 1'b0;
        ref_tmr   <= 10'h000;
      end else begin
        ref_tmr <= ref_tmr + 10'h001;
      end
    end else if (relock && ck_rise) begin
      if (lock_cnt == XSDLL_M1)
        relock <= 1'b0;
      lock_cnt <= lock_cnt + 10'h001;
    end
  end
  // ----------------------------------------
  // Write burst sequencing
  // ----------------------------------------
  reg       pend_v, pend_chop, act_v, act_chop, got_first, last_chop;
  reg [4:0] pend_cnt;
  reg [2:0] pend_bank, pend_col, act_bank, act_col, win_ck;
  reg [3:0] beat, last_beats;
  reg [7:0] mem [0:15];
  wire      open_win = pend_v & (pend_cnt <= 5'h01) & ~act_v;
  wire      beat_ev  = act_v & (dqs_rise | (dqs_fall & got_first));
  wire [3:0] limit   = act_chop ? 4'h4 : 4'h8;
  wire [3:0] beat_n  = beat + {3'h0, beat_ev};
  // Chopped window stays to the full burst time so stray edges do not leak
  wire      close_w  = (beat_n == 4'h8) | (win_ck == 3'd`DDW_WIN_CK) |
                       ((win_ck == 3'd`DDW_CHOP_CK) & (beat_n >= limit));
  wire [2:0] widx    = act_col + beat[2:0];
  // Pending slot counts WL-1 clock edges, then hands over to the window
  always @(posedge clk) begin
    if (rst_all) begin
      pend_v    <= 1'b0;
      pend_chop <= 1'b0;
      pend_cnt  <= 5'h00;
      pend_bank <= 3'h0;
      pend_col  <= 3'h0;
    end else begin
      if (open_win)
        pend_v <= 1'b0;
      else if (ck_rise && pend_v && pend_cnt > 5'h01)
        pend_cnt <= pend_cnt - 5'h01;
      if (wr_cmd && bank_open[s_ba] && (!pend_v || open_win)) begin
        pend_v    <= 1'b1;
        pend_cnt  <= wl;
        pend_bank <= s_ba;
        pend_col  <= s_addr[2:0];
        pend_chop <= chop_sel(bl_mode, s_addr[12]);
      end
    end
  end
  // Capture window; only the first rising edge may start the burst
  always @(posedge clk) begin
    if (rst_all) begin
      act_v      <= 1'b0;
      act_chop   <= 1'b0;
      act_bank   <= 3'h0;
      act_col    <= 3'h0;
      got_first  <= 1'b0;
      beat       <= 4'h0;
      win_ck     <= 3'h0;
      last_beats <= 4'h0;
      last_chop  <= 1'b0;
    end else if (open_win) begin
      act_v     <= 1'b1;
      act_chop  <= pend_chop;
      act_bank  <= pend_bank;
      act_col   <= pend_col;
      got_first <= 1'b0;
      beat      <= 4'h0;
      win_ck    <= 3'h0;
    end else if (act_v) begin
      if (beat_ev) begin
        got_first <= 1'b1;
        beat      <= beat_n;
      end
      if (ck_rise)
        win_ck <= win_ck + 3'h1;
      if (close_w) begin
        act_v      <= 1'b0;
        last_beats <= (beat_n > limit) ? limit : beat_n;
        last_chop  <= act_chop;
      end
    end
  end
  // Byte storage; masked or chopped beats leave it untouched
  always @(posedge clk) begin
    if (beat_ev && beat < limit && !s_dm)
      mem[{act_bank[0], widx}] <= s_dq;
  end
  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire is_dat = (paddr >= `DDW_OFF_DATA) & (paddr <= `DDW_OFF_DATA_END);
  wire valid  = (paddr[1:0] == 2'h0) & (is_dat | (paddr == `DDW_OFF_MODE) |
                (paddr == `DDW_OFF_STAT) | (paddr == `DDW_OFF_RFCNT) |
                (paddr == `DDW_OFF_WINFO));
  wire wr_stat = access & pwrite & (paddr == `DDW_OFF_STAT);
  wire odt_set = sr_entry & s_odt & rtt_on;
  wire werr_set = wr_cmd & (~bank_open[s_ba] | (pend_v & ~open_win));
  wire [31:0] stat = {18'h00000, act_v | pend_v, wr_err, odt_err, relock, dll_en, sr,
                      bank_open};
  assign pready  = 1'b1;
  assign pslverr = access & ~valid;
  // Mode write and sticky flags; a new event beats a clear
  always @(posedge clk) begin
    if (!rst_n) begin
      mode    <= `DDW_MODE_RST;
      odt_err <= 1'b0;
      wr_err  <= 1'b0;
    end else begin
      if (access && pwrite && paddr == `DDW_OFF_MODE)
        mode <= {20'h00000, pwdata[11:0]};
      odt_err <= odt_set | (odt_err & ~(wr_stat & pwdata[`DDW_STAT_ODT_BIT]));
      wr_err  <= werr_set | (wr_err & ~(wr_stat & pwdata[`DDW_STAT_WERR_BIT]));
    end
  end
  // Read data is registered in the setup cycle
  always @(posedge clk) begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (setup) begin
      case (paddr)
        `DDW_OFF_MODE:  prdata <= mode;
        `DDW_OFF_STAT:  prdata <= stat;
        `DDW_OFF_RFCNT: prdata <= ref_cnt;
        `DDW_OFF_WINFO: prdata <= {27'h0000000, last_chop, last_beats};
        default:        prdata <= (is_dat && valid) ? {24'h0, mem[paddr[5:2]]} : 32'h0;
      endcase
    end
  end
endmodule // ddw_top

// [verification/ddw_top_properties.sv]
// APB-side assertions for the DDR3 device write, precharge and self refresh logic
`timescale 1ns/10ps
module ddw_top_checker (
  input wire        clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  // Access phase of any transfer
  wire acc;
  assign acc = psel && penable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A read is a setup cycle followed by its access cycle
  sequence s_setup; psel && !penable && !pwrite; endsequence
  sequence s_rd; s_setup ##1 acc; endsequence
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_err_mis; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_err_mis: assert property (p_err_mis) else $error("misaligned access not refused");
  property p_err_only; pslverr |-> acc; endproperty
  a_err_only: assert property (p_err_only) else $error("error outside access phase");
  property p_err_ok; acc && paddr <= 12'h00C && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_err_ok: assert property (p_err_ok) else $error("mapped register refused");
  property p_err_zero; acc && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
  // Read data must not move after the access it answered
  property p_rd_hold; s_rd ##1 1'b1 |-> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved after access");
  property p_dll; acc && !pwrite && paddr == 12'h004 && prdata[8] |-> !prdata[9]; endproperty
  a_dll: assert property (p_dll) else $error("DLL on in self refresh");
  property p_chop; acc && !pwrite && paddr == 12'h00C && prdata[4] |-> prdata[3:0] <= 4'h4;
  endproperty
  a_chop: assert property (p_chop) else $error("chopped burst kept over four");
endmodule // ddw_top_checker

bind ddw_top ddw_top_checker chk_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr);

// [verification/ddw_ctrl_model.sv]
// Behavioural DDR3 controller driving commands, strobe and write data
`timescale 1ns/10ps
module ddw_ctrl_model (
  output logic        ck,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [13:0] addr,
  output logic [2:0]  ba,
  output logic        odt,
  output logic        mem_reset_n,
  output logic        dqs,
  output logic [7:0]  dq,
  output logic        dm
);
  // Idle: NOP, CKE high, strobe parked high, device reset held low a while
  initial begin
    {ck, cke, odt, mem_reset_n, dqs, dm} = 6'h12;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    {addr, ba, dq} = 25'h0;
    #400 mem_reset_n = 1'h1;
  end
  // Free running; slow against the two-flop pin path
  always #80 ck = ~ck;
  // Pins move on falling ck so each command is centred on a rising edge
  task cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic k);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    cke = k;
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    addr = ~a;
  endtask
  // Preamble, eight strobe edges with centred data, then postamble; a chop
  // still runs the full burst time, so later commands follow tBL and tWR
  task burst(input int wl, input logic [7:0] base, input logic [7:0] mk);
    repeat (wl - 1) @(negedge ck);
    dqs = 1'h0;
    for (int i = 0; i < 8; i++) begin
      #40 dq = base + 8'(i);
      dm = mk[i];
      #40 dqs = ~dqs;
    end
    #80 dqs = 1'h1;
    dq = ~dq;
    dm = ~dm;
  endtask
endmodule // ddw_ctrl_model

// [verification/test_ddw_top.sv]
// Self-checking bench for the DDR3 device write, precharge and self refresh logic
`timescale 1ns/10ps
`include "ddw_defines.vh"
module test_ddw_top;
  typedef struct {logic [31:0] mode; logic a12; logic [2:0] col; logic [7:0] base;
    logic [7:0] mk; logic [7:0] winfo; logic [3:0] idx; logic [7:0] exp;} ddw_row_t;
  logic        clk, rst_n, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, ck, cke, cs_n, ras_n, cas_n, we_n, odt, mem_reset_n, dqs, dm;
  wire  [13:0] addr;
  wire  [2:0]  ba;
  wire  [7:0]  dq;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  // MODE, A12, column, data base, mask, WINFO (FF skips), DATA index, byte
  ddw_row_t rows [6] = '{
    '{32'h140, 1'h0, 3'h0, 8'h10, 8'h00, 8'h08, 4'h7, 8'h17},
    '{32'h141, 1'h1, 3'h3, 8'h20, 8'h00, 8'h08, 4'h2, 8'h27},
    '{32'h141, 1'h0, 3'h0, 8'h30, 8'h00, 8'h14, 4'h5, 8'h22},
    '{32'h142, 1'h1, 3'h4, 8'h40, 8'h00, 8'h14, 4'h0, 8'h30},
    '{32'h140, 1'h0, 3'h0, 8'h50, 8'h04, 8'h08, 4'h2, 8'h32},
    '{32'h144, 1'h0, 3'h0, 8'h60, 8'h00, 8'h08, 4'h1, 8'h61}};

  ddw_top dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .ba, .odt, .mem_reset_n,
    .dqs, .dq, .dm);
  ddw_ctrl_model m (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .addr, .ba, .odt, .mem_reset_n,
    .dqs, .dq, .dm);

  always #5 clk = ~clk;

  // One APB transfer; leaves read data and error flag in rd and er
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Only the watchdog ends a transfer that never sees ready
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdst;
    apb(1'h0, `DDW_OFF_STAT, 32'h0);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog; the run needs about 1400 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim;
    end
  end

  initial begin
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = 49'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (60) @(posedge clk);
    m.cmd(`DDW_CMD_ACT, 3'h0, 14'h0000, 1'h1);
    // Bursts in every burst mode, chop with surplus strobes, mask, added latency
    foreach (rows[i]) begin
      apb(1'h1, `DDW_OFF_MODE, rows[i].mode);
      m.cmd(`DDW_CMD_WR, 3'h0, {1'h0, rows[i].a12, 9'h000, rows[i].col}, 1'h1);
      m.burst(rows[i].mode[5:2] + rows[i].mode[9:6], rows[i].base, rows[i].mk);
      apb(1'h0, `DDW_OFF_WINFO, 32'h0);
      if (rows[i].winfo != 8'hFF) chk(rd, {24'h0, rows[i].winfo});
      apb(1'h0, `DDW_OFF_DATA + {6'h00, rows[i].idx, 2'h0}, 32'h0);
      chk(rd, {24'h0, rows[i].exp});
      $display("burst row %0d done", i);
    end
    // One bank by BA, then all with A10 high; write to a closed bank refused
    m.cmd(`DDW_CMD_ACT, 3'h1, 14'h0000, 1'h1);
    m.cmd(`DDW_CMD_ACT, 3'h2, 14'h0000, 1'h1);
    m.cmd(`DDW_CMD_PRE, 3'h1, 14'h0000, 1'h1);
    rdst;
    chk(rd & 32'hFF, 32'h05);
    m.cmd(`DDW_CMD_PRE, 3'h6, 14'h0400, 1'h1);
    rdst;
    chk(rd & 32'hFF, 32'h00);
    m.cmd(`DDW_CMD_WR, 3'h0, 14'h0000, 1'h1);
    rdst;
    chk(rd & 32'h1000, 32'h1000);
    apb(1'h1, `DDW_OFF_STAT, 32'h1000);
    $display("precharge test done");
    // Termination on and ODT left high at entry; ACT in self refresh ignored
    apb(1'h1, `DDW_OFF_MODE, 32'h540);
    m.odt = 1'h1;
    m.cmd(`DDW_CMD_REF, 3'h0, 14'h0000, 1'h0);
    m.odt = 1'h0;
    m.cmd(`DDW_CMD_ACT, 3'h3, 14'h0000, 1'h0);
    rdst;
    chk(rd & 32'h1FFF, 32'h900);
    apb(1'h0, `DDW_OFF_RFCNT, 32'h0);
    chk(rd, 32'h1);
    m.cmd(4'h7, 3'h0, 14'h0000, 1'h1);
    rdst;
    chk(rd & 32'h700, 32'h600);
    $display("self refresh test done");
    // Unmapped read is refused with zero data; misaligned read is refused, its data not checked
    apb(1'h0, 12'h100, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'h0, 12'h002, 32'h0);
    chk({31'h0, er}, 32'h1);
    // A second reset in mid-run restores MODE
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, `DDW_OFF_MODE, 32'h0);
    chk(rd, 32'h140);
    $display("error and reset test done");
    end_sim;
  end
endmodule // test_ddw_top
